// ==== rtl/idle_wake_pkg.sv ====
// Purpose: shared constants and types for the idle mode wake controller
// Assumes: 250 MHz aclk, AXI4-Lite register access
// Notes: offsets are byte addresses of aligned 32-bit words
package idle_wake_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] ctrl_off = 8'h00;
  localparam logic [7:0] status_off = 8'h04;
  localparam logic [7:0] cmd_off = 8'h08;
  localparam logic [7:0] irq_off = 8'h0c;
  // ctrl field positions
  localparam int idle_select_pos = 0;
  localparam int clock_source_select_pos = 1;
  localparam int internal_freq_select_pos = 4;
  localparam int low_freq_source_select_pos = 7;
  localparam int secondary_osc_enable_pos = 8;
  localparam int watchdog_enable_pos = 9;
  localparam int clock_fail_monitor_pos = 10;
  localparam int two_speed_start_pos = 11;
  localparam int internal_is_primary_pos = 12;
  // cmd field positions
  localparam int cmd_sleep_pos = 0;
  localparam int cmd_wdt_clear_pos = 1;
  // reset values
  localparam logic [31:0] ctrl_reset = 32'h0000_0000;
  // ****************************************
  // timing
  // ****************************************
  localparam int clk_period_ps = 4000;
  localparam int cpu_startup_delay_ps = 2000000;
  localparam int internal_osc_settle_ps = 1000000;
  localparam int cpu_startup_cycles = (cpu_startup_delay_ps + clk_period_ps - 1) / clk_period_ps;
  localparam int internal_osc_settle_cycles = (internal_osc_settle_ps + clk_period_ps - 1) / clk_period_ps;
  localparam int osc_startup_cycles = 1024;
  localparam int wdt_timeout_cycles = 4096;
  localparam logic [1:0] resp_okay = 2'b00;
  localparam logic [1:0] resp_slverr = 2'b10;
  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    st_run = 3'b000,
    st_idle = 3'b001,
    st_sleep = 3'b010,
    st_wake = 3'b011,
    st_reset_hold = 3'b100
  } pm_state_t;
  typedef enum logic [1:0] {
    src_primary = 2'b00,
    src_secondary = 2'b01,
    src_internal = 2'b10
  } clk_src_t;
  typedef struct packed {
    logic primary_clock_ready_flag;
    logic internal_osc_stable_flag;
    logic secondary_osc_running_flag;
  } clk_flags_t;
endpackage

// ==== rtl/idle_mode_wake_controller.sv ====
// Purpose: idle and sleep entry, wake-up and cpu restart timing
// Assumes: oscillator and irq inputs are asynchronous pins; cpu strobes are on aclk
// Notes: registers over AXI4-Lite, one write and one read at a time
`timescale 1ns/10ps
// Contract
// - idle sleep gates cpu, keeps peripherals
// - idle keeps watchdog osc and secondary
// - only irq, watchdog, reset wake
// - wait startup delay, resume same source
// - wake leaves idle and source selects
// - watchdog in idle or sleep wakes
// - primary idle keeps primary ready flag
// - secondary idle stops primary, sets running
// - secondary disabled ignores sleep, clocks keep running
// - secondary wake keeps secondary clocking
// - high select chooses internal idle
// - internal output enabled, flag after settling
// - already stable flag stays set
// - all zero leaves output off
// - internal wake, slow osc stays on
// - enabled irq flag starts exit
// - branch to vector if global enable
// - resume first cycle after delay
// - watchdog in run resets device
// - watchdog cleared by listed events
// - reset exit waits startup timer
// - two-speed runs internal during startup
// - startup delay runs concurrently; ost_ff stops counting once run is entered
module idle_mode_wake_controller #(
  parameter int wdt_cycles = idle_wake_pkg::wdt_timeout_cycles
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sleep_op,
  input wire logic watchdog_clear_op,
  input wire logic global_irq_enable,
  input wire logic [7:0] irq_flag_pin,
  input wire logic primary_osc_ok_pin,
  input wire logic secondary_osc_ok_pin,
  input wire logic selected_clock_lost_pin,
  output logic cpu_clock_en,
  output logic periph_clock_en,
  output logic [1:0] periph_clock_source,
  output logic [1:0] cpu_clock_source,
  output logic primary_osc_on,
  output logic secondary_osc_on,
  output logic slow_internal_oscillator_on,
  output logic fast_internal_oscillator_on,
  output logic primary_clock_ready_flag,
  output logic internal_osc_stable_flag,
  output logic secondary_osc_running_flag,
  output logic branch_to_vector,
  output logic resume_pulse,
  output logic watchdog_reset
);
  // ****************************************
  // synchronisers for pins
  // ****************************************
  logic [10:0] meta_ff, sync_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_ff <= 11'h000;
      sync_ff <= 11'h000;
    end else begin
      meta_ff <= {selected_clock_lost_pin, secondary_osc_ok_pin, primary_osc_ok_pin, irq_flag_pin};
      sync_ff <= meta_ff;
    end
  end
  wire [7:0] irq_flag = sync_ff[7:0];
  wire primary_ok = sync_ff[8];
  wire secondary_ok = sync_ff[9];
  wire clock_lost = sync_ff[10];

  // ****************************************
  // register bus slave
  // ****************************************
  logic [31:0] ctrl_ff;
  logic [7:0] irq_enable_ff;
  logic aw_ff, w_ff, bvalid_ff, rvalid_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff, rdata_ff;
  logic [1:0] bresp_ff, rresp_ff;
  // address and data may arrive in either order
  assign s_axi_awready = !aw_ff && !bvalid_ff;
  assign s_axi_wready = !w_ff && !bvalid_ff;
  assign s_axi_arready = !rvalid_ff;
  wire do_write = aw_ff && w_ff && !bvalid_ff;
  wire wr_ctrl = do_write && awaddr_ff == idle_wake_pkg::ctrl_off;
  wire wr_cmd = do_write && awaddr_ff == idle_wake_pkg::cmd_off;
  wire wr_irq = do_write && awaddr_ff == idle_wake_pkg::irq_off;
  wire wr_status = do_write && awaddr_ff == idle_wake_pkg::status_off;
  wire wr_ok = wr_ctrl || wr_cmd || wr_irq || wr_status;
  wire [31:0] nxt_ctrl = wr_ctrl ? wdata_ff : ctrl_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      bresp_ff <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
      end
      if (do_write) begin
        aw_ff <= 1'b0;
        w_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_ok ? idle_wake_pkg::resp_okay : idle_wake_pkg::resp_slverr;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end
  // control word and irq enables, full-word writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= idle_wake_pkg::ctrl_reset;
      irq_enable_ff <= 8'h00;
    end else begin
      ctrl_ff <= nxt_ctrl;
      if (wr_irq) begin
        irq_enable_ff <= wdata_ff[7:0];
      end
    end
  end
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  // ****************************************
  // control fields
  // ****************************************
  wire idle_select = ctrl_ff[idle_wake_pkg::idle_select_pos];
  wire [1:0] clock_source_select = ctrl_ff[idle_wake_pkg::clock_source_select_pos +: 2];
  wire clock_select_high = clock_source_select[1];
  wire [2:0] internal_freq_select = ctrl_ff[idle_wake_pkg::internal_freq_select_pos +: 3];
  wire low_freq_source_select = ctrl_ff[idle_wake_pkg::low_freq_source_select_pos];
  wire secondary_osc_enable = ctrl_ff[idle_wake_pkg::secondary_osc_enable_pos];
  wire watchdog_enable = ctrl_ff[idle_wake_pkg::watchdog_enable_pos];
  wire clock_fail_monitor = ctrl_ff[idle_wake_pkg::clock_fail_monitor_pos];
  wire two_speed_start = ctrl_ff[idle_wake_pkg::two_speed_start_pos];
  wire internal_is_primary = ctrl_ff[idle_wake_pkg::internal_is_primary_pos];
  // software strobes on bus or cpu side
  wire sleep_req = sleep_op || (wr_cmd && wdata_ff[idle_wake_pkg::cmd_sleep_pos]);
  wire wdt_clear_req = watchdog_clear_op || (wr_cmd && wdata_ff[idle_wake_pkg::cmd_wdt_clear_pos]);

  // ****************************************
  // power state machine
  // ****************************************
  idle_wake_pkg::pm_state_t state_ff, nxt_state;
  idle_wake_pkg::clk_src_t src_ff, nxt_src;
  logic [19:0] delay_ff, nxt_delay;
  logic [19:0] ost_ff, nxt_ost;
  logic [19:0] settle_ff;
  logic [31:0] wdt_ff;
  logic irq_wake_ff, vector_ff, resume_ff, wdt_reset_ff, fast_stable_ff;
  // source picked by selects, high bit wins over low
  wire [1:0] sel_src = clock_select_high ? idle_wake_pkg::src_internal : clock_source_select;
  wire fast_needed = internal_freq_select != 3'h0 || low_freq_source_select;
  wire irq_wake = |(irq_flag & irq_enable_ff);
  wire wdt_timeout = watchdog_enable && wdt_ff == 32'(wdt_cycles - 1);
  wire in_pm = state_ff == idle_wake_pkg::st_idle || state_ff == idle_wake_pkg::st_sleep;
  wire wake_event = in_pm && (irq_wake || wdt_timeout);
  // idle entry into secondary with oscillator off is dropped
  wire sleep_ignored = idle_select && sel_src == idle_wake_pkg::src_secondary && !secondary_osc_enable;
  wire sleep_take = state_ff == idle_wake_pkg::st_run && sleep_req && !sleep_ignored;
  // watchdog restarts on sleep, clear op, lost clock with monitor on, freq write in internal
  wire freq_write = wr_ctrl && wdata_ff[idle_wake_pkg::internal_freq_select_pos +: 3] != internal_freq_select;
  wire wdt_clear = sleep_req || wdt_clear_req || (clock_fail_monitor && clock_lost)
    || (freq_write && src_ff == idle_wake_pkg::src_internal);
  always_comb begin
    nxt_state = state_ff;
    nxt_src = src_ff;
    nxt_delay = delay_ff;
    nxt_ost = ost_ff;
    unique case (state_ff)
      idle_wake_pkg::st_run: begin
        if (sleep_take) begin
          nxt_state = idle_select ? idle_wake_pkg::st_idle : idle_wake_pkg::st_sleep;
          nxt_src = idle_wake_pkg::clk_src_t'(sel_src);
        end
      end
      idle_wake_pkg::st_idle, idle_wake_pkg::st_sleep: begin
        if (wake_event) begin
          nxt_state = idle_wake_pkg::st_wake;
          nxt_src = idle_wake_pkg::clk_src_t'(sel_src);
          nxt_delay = 20'(idle_wake_pkg::cpu_startup_cycles - 1);
        end
      end
      idle_wake_pkg::st_wake: begin
        if (delay_ff != 20'h00000) begin
          nxt_delay = delay_ff - 20'h00001;
        end else if (src_ff != idle_wake_pkg::src_primary || primary_ok) begin
          nxt_state = idle_wake_pkg::st_run;
        end
      end
      idle_wake_pkg::st_reset_hold: begin
        if (ost_ff != 20'h00000) begin
          nxt_ost = ost_ff - 20'h00001;
        end else if (primary_ok || internal_is_primary) begin
          nxt_state = idle_wake_pkg::st_run;
          nxt_src = idle_wake_pkg::src_primary;
        end
        if (two_speed_start || clock_fail_monitor) begin
          nxt_state = idle_wake_pkg::st_run;
          nxt_src = (primary_ok && ost_ff == 20'h00000) ? idle_wake_pkg::src_primary : idle_wake_pkg::src_internal;
        end
      end
      default: nxt_state = idle_wake_pkg::st_reset_hold;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= idle_wake_pkg::st_reset_hold;
      src_ff <= idle_wake_pkg::src_primary;
      delay_ff <= 20'h00000;
      ost_ff <= 20'(idle_wake_pkg::osc_startup_cycles - 1);
    end else begin
      state_ff <= nxt_state;
      src_ff <= nxt_src;
      delay_ff <= nxt_delay;
      ost_ff <= nxt_ost;
    end
  end
  // two-speed: pending flag clears once primary is ready in run, or on sleep; src_ff is not switched
  logic handover_pending_ff;
  wire handover = handover_pending_ff && state_ff == idle_wake_pkg::st_run && primary_ok;
  // watchdog, wake cause and exit outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wdt_ff <= 32'h0000_0000;
      irq_wake_ff <= 1'b0;
      vector_ff <= 1'b0;
      resume_ff <= 1'b0;
      wdt_reset_ff <= 1'b0;
      handover_pending_ff <= 1'b0;
    end else begin
      wdt_ff <= (wdt_clear || wdt_timeout || !watchdog_enable) ? 32'h0000_0000 : wdt_ff + 32'h0000_0001;
      if (wake_event) begin
        irq_wake_ff <= irq_wake;
      end
      resume_ff <= state_ff == idle_wake_pkg::st_wake && nxt_state == idle_wake_pkg::st_run;
      vector_ff <= state_ff == idle_wake_pkg::st_wake && nxt_state == idle_wake_pkg::st_run
        && irq_wake_ff && global_irq_enable;
      wdt_reset_ff <= wdt_timeout && state_ff == idle_wake_pkg::st_run;
      if (state_ff == idle_wake_pkg::st_reset_hold) begin
        handover_pending_ff <= nxt_src == idle_wake_pkg::src_internal;
      end else if (handover || sleep_take) begin
        handover_pending_ff <= 1'b0;
      end
    end
  end
  // ****************************************
  // internal oscillator settling
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      settle_ff <= 20'h00000;
      fast_stable_ff <= 1'b0;
    end else if (!fast_needed) begin
      settle_ff <= 20'h00000;
      fast_stable_ff <= 1'b0;
    end else if (!fast_stable_ff) begin
      settle_ff <= settle_ff + 20'h00001;
      fast_stable_ff <= settle_ff == 20'(idle_wake_pkg::internal_osc_settle_cycles - 1);
    end
  end
  // ****************************************
  // clock gating and status flags
  // ****************************************
  wire running = state_ff == idle_wake_pkg::st_run;
  wire on_sec = src_ff == idle_wake_pkg::src_secondary;
  wire on_int = src_ff == idle_wake_pkg::src_internal;
  wire asleep = state_ff == idle_wake_pkg::st_sleep || state_ff == idle_wake_pkg::st_reset_hold;
  assign cpu_clock_en = running;
  // peripherals wait for a started secondary oscillator
  assign periph_clock_en = !asleep && !(on_sec && !secondary_ok);
  assign periph_clock_source = src_ff;
  assign cpu_clock_source = src_ff;
  assign primary_osc_on = !on_int && !on_sec && state_ff != idle_wake_pkg::st_sleep;
  assign secondary_osc_on = secondary_osc_enable;
  assign slow_internal_oscillator_on = watchdog_enable || clock_fail_monitor || (on_int && !asleep);
  assign fast_internal_oscillator_on = fast_needed;
  idle_wake_pkg::clk_flags_t flags;
  always_comb begin
    flags.primary_clock_ready_flag = !asleep && !on_sec && !on_int && primary_ok;
    // gated by fast_needed so the flag drops in the same cycle as the output
    flags.internal_osc_stable_flag = !asleep && fast_needed && fast_stable_ff && (on_int || internal_is_primary);
    flags.secondary_osc_running_flag = !asleep && on_sec && secondary_ok;
  end
  assign primary_clock_ready_flag = flags.primary_clock_ready_flag;
  assign internal_osc_stable_flag = flags.internal_osc_stable_flag;
  assign secondary_osc_running_flag = flags.secondary_osc_running_flag;
  assign branch_to_vector = vector_ff;
  assign resume_pulse = resume_ff;
  assign watchdog_reset = wdt_reset_ff;

  // ****************************************
  // read channel
  // ****************************************
  wire [31:0] status_word = {24'h000000, 2'b00, flags, state_ff};
  wire [31:0] rd_mux = s_axi_araddr == idle_wake_pkg::ctrl_off ? ctrl_ff
    : s_axi_araddr == idle_wake_pkg::status_off ? status_word
    : s_axi_araddr == idle_wake_pkg::irq_off ? {24'h000000, irq_enable_ff} : 32'h0000_0000;
  wire rd_ok = s_axi_araddr == idle_wake_pkg::ctrl_off || s_axi_araddr == idle_wake_pkg::status_off
    || s_axi_araddr == idle_wake_pkg::irq_off || s_axi_araddr == idle_wake_pkg::cmd_off;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_mux;
      rresp_ff <= rd_ok ? idle_wake_pkg::resp_okay : idle_wake_pkg::resp_slverr;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  // ****************************************
  // assertions
  // ****************************************
  a_idle_cpu_off: assert property (@(posedge aclk) disable iff (!aresetn)
    in_pm |-> !cpu_clock_en) else $error("cpu clock runs in idle");
  a_wake_cause_only: assert property (@(posedge aclk) disable iff (!aresetn)
    (in_pm && !irq_wake && !wdt_timeout) |=> state_ff != idle_wake_pkg::st_wake) else $error("wake without cause");
  a_wake_delay_len: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(state_ff == idle_wake_pkg::st_wake) |-> !cpu_clock_en [*8]) else $error("cpu started early");
  a_wake_keeps_sel: assert property (@(posedge aclk) disable iff (!aresetn)
    wake_event && !wr_ctrl |=> $stable(ctrl_ff)) else $error("wake changed selects");
  a_run_wdt_reset: assert property (@(posedge aclk) disable iff (!aresetn)
    (running && wdt_timeout) |=> watchdog_reset) else $error("no watchdog reset in run");
  a_sec_ignored: assert property (@(posedge aclk) disable iff (!aresetn)
    (running && sleep_req && sleep_ignored) |=> running) else $error("ignored sleep taken");
  a_fast_off_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    !fast_needed |-> !internal_osc_stable_flag && !fast_internal_oscillator_on) else $error("fast flag w/o output");
  a_vector_gated: assert property (@(posedge aclk) disable iff (!aresetn)
    branch_to_vector |-> resume_pulse && $past(global_irq_enable)) else $error("branch without enable");
  a_sec_primary_off: assert property (@(posedge aclk) disable iff (!aresetn)
    on_sec |-> !primary_osc_on && !primary_clock_ready_flag) else $error("primary on in secondary");
  c_idle_wake: cover property (@(posedge aclk) disable iff (!aresetn) in_pm ##1 state_ff == idle_wake_pkg::st_wake);
  c_resume: cover property (@(posedge aclk) disable iff (!aresetn) resume_pulse);
  c_wdt_reset: cover property (@(posedge aclk) disable iff (!aresetn) watchdog_reset);
endmodule

// ==== testbench/osc_irq_model.sv ====
// Purpose: far-side model of oscillators and interrupt sources
// Assumes: start-up counts are kept short for simulation
// Notes: interrupt flags follow the request vector of the bench
`timescale 1ns/10ps
module osc_irq_model #(
  parameter int pri_start = 20,
  parameter int sec_start = 40
) (
  input wire logic aclk,
  input wire logic primary_osc_on,
  input wire logic secondary_osc_on,
  input wire logic [7:0] irq_req,
  output logic primary_osc_ok_pin,
  output logic secondary_osc_ok_pin,
  output logic [7:0] irq_flag_pin
);
  int pri_cnt = 0;
  int sec_cnt = 0;
  // ****************************************
  // oscillator start-up and flags
  // ****************************************
  initial begin
    primary_osc_ok_pin = 1'b0;
    secondary_osc_ok_pin = 1'b0;
    irq_flag_pin = 8'h00;
  end
  // an oscillator reports good only after its start-up count
  always @(posedge aclk) begin
    pri_cnt <= primary_osc_on ? pri_cnt + 1 : 0;
    sec_cnt <= secondary_osc_on ? sec_cnt + 1 : 0;
    primary_osc_ok_pin <= primary_osc_on && pri_cnt >= pri_start;
    secondary_osc_ok_pin <= secondary_osc_on && sec_cnt >= sec_start;
    irq_flag_pin <= irq_req;
  end
endmodule

// ==== testbench/idle_mode_wake_controller_bench.sv ====
// Purpose: self-checking bench for the idle mode wake controller
// Assumes: 4 ns aclk, watchdog shortened to 64 cycles
// Notes: oscillator pins and flags come from the far-side model
`timescale 1ns/10ps
module idle_mode_wake_controller_bench;
  logic aclk = 1'b0, aresetn = 1'b0, sleep_op = 1'b0, wdt_clr = 1'b0, gie = 1'b0, lost = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, irq_req = 8'h00, irq_pin;
  logic [31:0] wdata = 32'h0000_0000, rdata, d;
  logic [1:0] bresp, rresp, r, per_src, cpu_src;
  logic awready, wready, bvalid, arready, rvalid, cpu_en, per_en, pri_on, sec_on, slow_on, fast_on;
  logic f_pri, f_int, f_sec, branch, resume, wdt_rst, pri_ok, sec_ok, br, saw_rst;
  int failures = 0, n_checks = 0, n;
  // ****************************************
  // clock, design and far side
  // ****************************************
  always #2 aclk = ~aclk;
  idle_mode_wake_controller #(.wdt_cycles(64)) i_idle_mode_wake_controller (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .sleep_op(sleep_op), .watchdog_clear_op(wdt_clr), .global_irq_enable(gie),
    .irq_flag_pin(irq_pin), .primary_osc_ok_pin(pri_ok), .secondary_osc_ok_pin(sec_ok),
    .selected_clock_lost_pin(lost), .cpu_clock_en(cpu_en), .periph_clock_en(per_en),
    .periph_clock_source(per_src), .cpu_clock_source(cpu_src), .primary_osc_on(pri_on),
    .secondary_osc_on(sec_on), .slow_internal_oscillator_on(slow_on), .fast_internal_oscillator_on(fast_on),
    .primary_clock_ready_flag(f_pri), .internal_osc_stable_flag(f_int), .secondary_osc_running_flag(f_sec),
    .branch_to_vector(branch), .resume_pulse(resume), .watchdog_reset(wdt_rst));
  osc_irq_model i_osc_irq_model (.aclk(aclk), .primary_osc_on(pri_on), .secondary_osc_on(sec_on),
    .irq_req(irq_req), .primary_osc_ok_pin(pri_ok), .secondary_osc_ok_pin(sec_ok), .irq_flag_pin(irq_pin));
  // remembers any watchdog reset pulse
  always @(posedge aclk) if (wdt_rst === 1'b1) saw_rst <= 1'b1;
  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (!aw && awready === 1'b1) begin aw = 1'b1; awvalid <= 1'b0; end
      if (!w && wready === 1'b1) begin w = 1'b1; wvalid <= 1'b0; end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    r = bresp;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
    @(posedge aclk);
  endtask
  task automatic sleep();
    sleep_op <= 1'b1;
    @(posedge aclk);
    sleep_op <= 1'b0;
  endtask
  task automatic wait_hi(input int sel);
    logic s;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      case (sel)
        0: s = cpu_en;
        1: s = resume;
        default: s = wdt_rst;
      endcase
    end while (s !== 1'b1 && n < 3000);
    br = branch;
    chk("awaited signal", {31'h0, s}, 32'h1);
  endtask
  // ****************************************
  // tests
  // ****************************************
  initial begin
    cyc(4); aresetn <= 1'b1;
    wait_hi(0); chk("ready flag", f_pri, 1);
    rd(idle_wake_pkg::ctrl_off); chk("ctrl reset", d, idle_wake_pkg::ctrl_reset);
    rd(8'h10); chk("unmapped resp", r, idle_wake_pkg::resp_slverr);
    $display("reset test done");
    wr(idle_wake_pkg::irq_off, 32'h1);
    chk("write resp", r, idle_wake_pkg::resp_okay);
    wr(idle_wake_pkg::ctrl_off, 32'h1); gie <= 1'b1; sleep(); cyc(3);
    chk("cpu gated", cpu_en, 0);
    chk("periph on", per_en, 1);
    chk("periph src", per_src, idle_wake_pkg::src_primary);
    rd(idle_wake_pkg::status_off); chk("idle status", d, 32'h21);
    irq_req <= 8'h02; cyc(30); chk("masked irq", cpu_en, 0);
    irq_req <= 8'h03; wait_hi(1); chk("wake time", n >= 500 && n <= 512, 1);
    chk("vector", br, 1);
    chk("cpu src", cpu_src, idle_wake_pkg::src_primary);
    chk("ready kept", f_pri, 1);
    rd(idle_wake_pkg::ctrl_off); chk("selects kept", d, 32'h1);
    $display("primary idle test done");
    irq_req <= 8'h00; wr(idle_wake_pkg::ctrl_off, 32'h3); sleep(); cyc(5);
    chk("sleep ignored", cpu_en, 1);
    wr(idle_wake_pkg::ctrl_off, 32'h103); sleep(); cyc(5); chk("periph held", per_en, 0);
    cyc(60); chk("periph on sec", per_en, 1);
    chk("primary off", pri_on, 0);
    chk("sec on", sec_on, 1);
    rd(idle_wake_pkg::status_off); chk("sec status", d, 32'h9);
    chk("sec flag", f_sec, 1);
    gie <= 1'b0; irq_req <= 8'h01; wait_hi(1); chk("no vector", br, 0);
    chk("cpu src sec", cpu_src, idle_wake_pkg::src_secondary);
    chk("sec kept", sec_on, 1);
    $display("secondary idle test done");
    irq_req <= 8'h00; wr(idle_wake_pkg::ctrl_off, 32'h7); sleep(); cyc(300);
    chk("periph src int", per_src, idle_wake_pkg::src_internal);
    chk("primary flag off", f_pri, 0);
    chk("no stable flag", f_int, 0);
    chk("fast off", fast_on, 0);
    irq_req <= 8'h01; wait_hi(1); chk("cpu src int", cpu_src, idle_wake_pkg::src_internal);
    irq_req <= 8'h00; wr(idle_wake_pkg::ctrl_off, 32'h35); cyc(200);
    chk("settling", f_int, 0);
    chk("fast on", fast_on, 1);
    cyc(80); chk("stable", f_int, 1);
    sleep(); cyc(2); chk("stays stable", f_int, 1);
    irq_req <= 8'h01; wait_hi(1); irq_req <= 8'h00;
    $display("internal idle test done");
    // plain sleep entered through the command register
    wr(idle_wake_pkg::ctrl_off, 32'h4);
    wr(idle_wake_pkg::cmd_off, 32'h1);
    cyc(3);
    chk("sleep periph off", per_en, 0);
    irq_req <= 8'h01;
    wait_hi(1);
    irq_req <= 8'h00;
    chk("sleep wake src", cpu_src, idle_wake_pkg::src_internal);
    $display("sleep test done");
    wr(idle_wake_pkg::ctrl_off, 32'h605); sleep(); cyc(3); chk("slow osc on", slow_on, 1);
    wait_hi(1); chk("wdt wake", n < 600, 1);
    chk("wake src", cpu_src, idle_wake_pkg::src_internal);
    saw_rst <= 1'b0;
    repeat (5) begin
      wdt_clr <= 1'b1; cyc(1); wdt_clr <= 1'b0; cyc(30);
    end
    // lost clock with the monitor on also restarts the watchdog
    lost <= 1'b1;
    cyc(1);
    lost <= 1'b0;
    cyc(30);
    chk("cleared wdt", saw_rst, 0);
    wait_hi(2); chk("run wdt reset", n <= 70, 1);
    $display("watchdog test done");
    tally_and_finish();
  end
  // cuts a hung run short
  initial begin
    #100000;
    failures++;
    tally_and_finish();
  end
endmodule
